// ==== core/apl_pkg.sv ====
// Functional notes
// - Load begin clears labels and sequences.
// - Only mode, clock, delay settings accepted.
// - Label name six chars, width 1-32.
// - Labels take contiguous bits, MSB first.
// - At most 126 labels; oversize discarded.
// - Format label command after begin errors.
// - Header is '#8' plus eight digits.
// - Bus transfer ends only at count.
// - First excess byte errors unless a lone LF; all excess bytes become remote commands.
// - Short transfer keeps waiting for bytes.
// - Disk load ignores count, ends at EOF.
// - Rows become lines, columns map labels.
// - Oversized field keeps its low bits.
// - Extra fields dropped, missing fields zero.
// - Empty rows create no program line.
// - Marker row switches to main sequence.
// - Non-hex characters separate fields.
// - Row commits only on its terminator.
// - Main sequence under two lines installs default main program.
package apl_pkg;
	// ----------------------------------------------------------------
	// Sizes and limits
	// ----------------------------------------------------------------
	localparam int NUM_LABELS = 126;
	localparam int OUT_BITS = 32;
	localparam int MAX_WIDTH = 32;
	localparam int NAME_CHARS = 6;
	localparam int HDR_DIGITS = 8;
	localparam int MIN_MAIN_ROWS = 2;
	localparam int CNT_W = 27;
	// ----------------------------------------------------------------
	// Character codes and keywords
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_QUOTE = 8'h27;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_EIGHT = 8'h38;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_9 = 8'h39;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_M = 8'h4d;
	localparam logic [7:0] CH_Z = 8'h5a;
	localparam logic [7:0] CASE_MASK = 8'hdf;
	localparam logic [31:0] KW_BEGIN = 32'h41534344;
	localparam logic [31:0] KW_LABEL = 32'h4c414245;
	localparam logic [31:0] KW_VECT = 32'h56454354;
	localparam logic [31:0] KW_FORM = 32'h464f524d;
	localparam logic [23:0] SUB_MODE = 24'h4d4f44;
	localparam logic [23:0] SUB_CLOCK = 24'h434c4f;
	localparam logic [23:0] SUB_DELAY = 24'h44454c;
	localparam logic [23:0] SUB_LABEL = 24'h4c4142;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {ERR_NONE, ERR_ORDER, ERR_FMT_LABEL, ERR_FMT_OTHER, ERR_LABEL,
		ERR_HEADER, ERR_OVERRUN, ERR_SHORT_MAIN, ERR_UNKNOWN} apl_err_t;
	typedef enum logic [1:0] {FMT_MODE, FMT_CLOCK, FMT_DELAY} apl_fmt_t;
	typedef struct packed {
		logic [6:0] idx;
		logic [5:0] msb;
		logic [5:0] width;
		logic [47:0] name;
	} apl_lbl_t;
	typedef struct packed {
		logic [6:0] idx;
		logic [5:0] width;
		logic [31:0] val;
		logic main;
		logic last;
	} apl_vec_t;
	typedef struct packed {
		logic [31:0] kw;
		logic [2:0] kwn;
		logic kwend;
		logic [23:0] sub;
		logic [1:0] subn;
		logic colon;
		logic quote;
		logic hash;
		logic collect;
		logic [47:0] name;
		logic [2:0] nlen;
		logic [31:0] num;
		logic [3:0] ndig;
	} apl_line_t;
endpackage : apl_pkg

// ==== core/apl_ram.sv ====
`timescale 1ns/1ns
module apl_ram #(
	parameter int W = 32,
	parameter int D = 126,
	parameter int AW = 7
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : apl_ram

// ==== core/apl_loader.sv ====
`timescale 1ns/1ns
module apl_loader #(
	parameter int NUM_LABELS = apl_pkg::NUM_LABELS,
	parameter int OUT_BITS = apl_pkg::OUT_BITS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	input wire logic src_disk,
	input wire logic src_eof,
	output logic rmt_valid,
	output logic [7:0] rmt_data,
	output logic seq_clear,
	output logic lbl_valid,
	output apl_pkg::apl_lbl_t lbl,
	output logic fmt_valid,
	output apl_pkg::apl_fmt_t fmt_sel,
	output logic vec_valid,
	output apl_pkg::apl_vec_t vec,
	output logic load_done,
	output logic dflt_main,
	output logic err_valid,
	output apl_pkg::apl_err_t err_code
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_DATA, ST_EMIT, ST_FINISH} apl_state_t;
	typedef enum logic [1:0] {MK_START, MK_STAR, MK_DONE, MK_BROKEN} apl_mark_t;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	apl_state_t st, next_st;
	apl_pkg::apl_line_t ln, next_ln;
	logic [31:0] cur, next_cur;
	logic infield, next_infield;
	logic [7:0] fidx, next_fidx;
	apl_mark_t mk, next_mk;
	logic [6:0] nlab, next_nlab;
	logic [6:0] used, next_used;
	logic [apl_pkg::CNT_W-1:0] cnt, next_cnt;
	logic main_seq, next_main;
	logic [1:0] rows, next_rows;
	logic post, next_post;
	logic fin, next_fin;
	logic [6:0] ei, next_ei;
	logic [7:0] efc, next_efc;
	logic ev1, next_ev1;
	logic [6:0] ei1, next_ei1;
	logic next_rmt_valid, next_clear, next_lbl_valid, next_fmt_valid;
	logic next_vec_valid, next_done, next_dflt, next_err_valid;
	logic [7:0] next_rmt_data;
	apl_pkg::apl_lbl_t next_lbl;
	apl_pkg::apl_fmt_t next_fmt;
	apl_pkg::apl_vec_t next_vec;
	apl_pkg::apl_err_t next_err;

	// ----------------------------------------------------------------
	// Character classes
	// ----------------------------------------------------------------
	logic in_fire, is_term, is_dig, is_let, lbl_ok, line_end, lbl_we, row_we;
	logic [7:0] up;
	logic [4:0] hexv;
	logic [7:0] fcount;
	logic [5:0] lbl_q;
	logic [31:0] row_q;

	function automatic logic [31:0] mask_of(input logic [5:0] w);
		mask_of = (w >= 6'(apl_pkg::MAX_WIDTH)) ? 32'hffffffff : 32'((32'h1 << w) - 32'h1);
	endfunction : mask_of

	assign in_ready = (st == ST_IDLE) || (st == ST_SETUP) || (st == ST_DATA);
	assign in_fire = in_valid && in_ready;
	assign up = in_data & apl_pkg::CASE_MASK;
	assign is_term = (in_data == apl_pkg::CH_CR) || (in_data == apl_pkg::CH_LF);
	assign is_dig = (in_data >= apl_pkg::CH_0) && (in_data <= apl_pkg::CH_9);
	assign is_let = (up >= apl_pkg::CH_A) && (up <= apl_pkg::CH_Z);
	// Anything that is not a hex digit falls out here and acts as a separator.
	assign hexv = is_dig ? {1'b1, in_data[3:0]} :
		((up >= apl_pkg::CH_A) && (up <= apl_pkg::CH_F)) ? {1'b1, 4'(up[3:0] + 4'h9)} : 5'h00;
	assign fcount = (infield && fidx != 8'hff) ? 8'(fidx + 8'h01) : fidx;
	assign line_end = in_fire && is_term && (st == ST_IDLE || st == ST_SETUP);
	assign lbl_ok = (st == ST_SETUP) && (ln.nlen != 3'h0) && (ln.nlen <= 3'(apl_pkg::NAME_CHARS))
		&& (ln.num >= 32'h1) && (ln.num <= 32'(apl_pkg::MAX_WIDTH))
		&& (int'(nlab) < NUM_LABELS) && (ln.num <= 32'(OUT_BITS - int'(used)));

	// ----------------------------------------------------------------
	// Label widths and the pending row
	// ----------------------------------------------------------------
	apl_ram #(.W(6), .D(apl_pkg::NUM_LABELS), .AW(7)) u_lbl_ram (
		.clk(clk),
		.we(lbl_we),
		.waddr(nlab),
		.wdata(ln.num[5:0]),
		.raddr(ei),
		.rdata(lbl_q)
	);

	// The row is held here until its terminator, so a cut-off last row never reaches the output.
	apl_ram #(.W(32), .D(apl_pkg::NUM_LABELS), .AW(7)) u_row_ram (
		.clk(clk),
		.we(row_we),
		.waddr(fidx[6:0]),
		.wdata(cur),
		.raddr(ei),
		.rdata(row_q)
	);

	// ----------------------------------------------------------------
	// Parser
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_ln = ln;
		next_cur = cur;
		next_infield = infield;
		next_fidx = fidx;
		next_mk = mk;
		next_nlab = nlab;
		next_used = used;
		next_cnt = cnt;
		next_main = main_seq;
		next_rows = rows;
		next_post = post;
		next_fin = fin;
		next_ei = ei;
		next_efc = efc;
		next_ev1 = 1'b0;
		next_ei1 = ei1;
		next_rmt_valid = in_fire && (st == ST_IDLE || st == ST_SETUP);
		next_rmt_data = in_fire ? in_data : rmt_data;
		next_clear = 1'b0;
		next_lbl_valid = 1'b0;
		next_lbl = lbl;
		next_fmt_valid = 1'b0;
		next_fmt = fmt_sel;
		next_err_valid = 1'b0;
		next_err = err_code;
		next_done = 1'b0;
		next_dflt = 1'b0;
		next_vec_valid = ev1;
		next_vec = vec;
		lbl_we = 1'b0;
		row_we = 1'b0;
		if (ev1) begin
			next_vec.idx = ei1;
			next_vec.width = lbl_q;
			next_vec.val = ({1'b0, ei1} < efc) ? (row_q & mask_of(lbl_q)) : 32'h0;
			next_vec.main = main_seq;
			next_vec.last = (ei1 == 7'(nlab - 7'h01));
		end
		// A lone line feed after the count is the network flush byte, not an overrun.
		if (st == ST_IDLE && post && in_fire) begin
			next_post = 1'b0;
			if (in_data != apl_pkg::CH_LF) begin
				next_err_valid = 1'b1;
				next_err = apl_pkg::ERR_OVERRUN;
			end
		end
		unique case (st)
			ST_IDLE, ST_SETUP: begin
				if (line_end) begin
					next_ln = '0;
					if (ln.kw == apl_pkg::KW_BEGIN) begin
						next_st = ST_SETUP;
						next_nlab = 7'h00;
						next_used = 7'h00;
						next_main = 1'b0;
						next_rows = 2'h0;
						next_post = 1'b0;
						next_clear = 1'b1;
					end else if ((ln.kw == apl_pkg::KW_LABEL || ln.kw == apl_pkg::KW_VECT)
						&& st == ST_IDLE) begin
						next_err_valid = 1'b1;
						next_err = apl_pkg::ERR_ORDER;
					end else if (ln.kw == apl_pkg::KW_LABEL) begin
						if (lbl_ok) begin
							lbl_we = 1'b1;
							next_lbl_valid = 1'b1;
							next_lbl.idx = nlab;
							next_lbl.msb = 6'(OUT_BITS - 1 - int'(used));
							next_lbl.width = ln.num[5:0];
							next_lbl.name = ln.name;
							next_nlab = 7'(nlab + 7'h01);
							next_used = 7'(used + ln.num[6:0]);
						end else begin
							next_err_valid = 1'b1;
							next_err = apl_pkg::ERR_LABEL;
						end
					end else if (ln.kw == apl_pkg::KW_VECT) begin
						next_cur = 32'h0;
						next_infield = 1'b0;
						next_fidx = 8'h00;
						next_mk = MK_START;
						next_fin = 1'b0;
						if (!src_disk && ln.ndig != 4'(apl_pkg::HDR_DIGITS)) begin
							next_err_valid = 1'b1;
							next_err = apl_pkg::ERR_HEADER;
						end
						if (src_disk) begin
							next_st = ST_DATA;
						end else if (ln.num <= 32'h1) begin
							next_st = ST_FINISH;
						end else begin
							// The header's own terminator is the first counted byte.
							next_cnt = apl_pkg::CNT_W'(ln.num - 32'h1);
							next_st = ST_DATA;
						end
					end else if (ln.kw == apl_pkg::KW_FORM && st == ST_SETUP) begin
						if (ln.sub == apl_pkg::SUB_MODE) begin
							next_fmt_valid = 1'b1;
							next_fmt = apl_pkg::FMT_MODE;
						end else if (ln.sub == apl_pkg::SUB_CLOCK) begin
							next_fmt_valid = 1'b1;
							next_fmt = apl_pkg::FMT_CLOCK;
						end else if (ln.sub == apl_pkg::SUB_DELAY) begin
							next_fmt_valid = 1'b1;
							next_fmt = apl_pkg::FMT_DELAY;
						end else begin
							next_err_valid = 1'b1;
							next_err = (ln.sub == apl_pkg::SUB_LABEL) ?
								apl_pkg::ERR_FMT_LABEL : apl_pkg::ERR_FMT_OTHER;
						end
					end else if (st == ST_SETUP && ln.kwn != 3'h0) begin
						next_err_valid = 1'b1;
						next_err = apl_pkg::ERR_UNKNOWN;
					end
				end else if (in_fire) begin
					if (in_data == apl_pkg::CH_QUOTE) begin
						next_ln.quote = !ln.quote;
					end else if (ln.quote) begin
						if (ln.nlen != 3'h7) begin
							next_ln.nlen = 3'(ln.nlen + 3'h1);
						end
						if (ln.nlen < 3'(apl_pkg::NAME_CHARS)) begin
							next_ln.name = {ln.name[39:0], in_data};
						end
					end else if (in_data == apl_pkg::CH_COLON) begin
						next_ln.colon = 1'b1;
						next_ln.kwend = 1'b1;
					end else if (in_data == apl_pkg::CH_COMMA) begin
						next_ln.collect = 1'b1;
					end else if (in_data == apl_pkg::CH_HASH) begin
						next_ln.hash = 1'b1;
					end else if (ln.hash && !ln.collect && in_data == apl_pkg::CH_EIGHT) begin
						next_ln.collect = 1'b1;
					end else if (ln.collect && is_dig) begin
						next_ln.num = 32'(ln.num * 32'd10 + {28'h0, in_data[3:0]});
						if (ln.ndig != 4'hf) begin
							next_ln.ndig = 4'(ln.ndig + 4'h1);
						end
					end else if (is_let && !ln.colon && !ln.kwend && ln.kwn < 3'h4) begin
						next_ln.kw = {ln.kw[23:0], up};
						next_ln.kwn = 3'(ln.kwn + 3'h1);
					end else if (is_let && ln.colon && ln.subn != 2'h3) begin
						next_ln.sub = {ln.sub[15:0], up};
						next_ln.subn = 2'(ln.subn + 2'h1);
					end else if (in_data == apl_pkg::CH_SP && ln.kwn != 3'h0) begin
						next_ln.kwend = 1'b1;
					end
				end
			end
			ST_DATA: begin
				if (in_fire) begin
					if (!src_disk) begin
						next_cnt = apl_pkg::CNT_W'(cnt - 1'b1);
					end
					if (hexv[4]) begin
						next_cur = {cur[27:0], hexv[3:0]};
						next_infield = 1'b1;
					end else if (infield) begin
						row_we = ({1'b0, fidx[6:0]} < {1'b0, nlab}) && !fidx[7];
						next_fidx = fcount;
						next_infield = 1'b0;
						next_cur = 32'h0;
					end
					if (!is_term) begin
						if (mk == MK_START && in_data == apl_pkg::CH_STAR) begin
							next_mk = MK_STAR;
						end else if (mk == MK_STAR && up == apl_pkg::CH_M) begin
							next_mk = MK_DONE;
						end else begin
							next_mk = MK_BROKEN;
						end
					end else begin
						next_cur = 32'h0;
						next_infield = 1'b0;
						next_fidx = 8'h00;
						next_mk = MK_START;
						if (mk == MK_DONE) begin
							next_main = 1'b1;
						end else if (fcount != 8'h00 && nlab != 7'h00) begin
							next_st = ST_EMIT;
							next_ei = 7'h00;
							next_efc = fcount;
							if (main_seq && rows < 2'(apl_pkg::MIN_MAIN_ROWS)) begin
								next_rows = 2'(rows + 2'h1);
							end
						end
					end
					// Short transfers simply sit here until the count is met.
					if (!src_disk && cnt == apl_pkg::CNT_W'(1)) begin
						next_fin = 1'b1;
						if (next_st != ST_EMIT) begin
							next_st = ST_FINISH;
						end
					end
				end else if (src_disk && src_eof) begin
					next_st = ST_FINISH;
				end
			end
			ST_EMIT: begin
				next_ev1 = 1'b1;
				next_ei1 = ei;
				if (ei == 7'(nlab - 7'h01)) begin
					next_st = fin ? ST_FINISH : ST_DATA;
				end else begin
					next_ei = 7'(ei + 7'h01);
				end
			end
			ST_FINISH: begin
				// Wait out the read pipe so the done pulse follows the last vector.
				if (!ev1) begin
					next_done = 1'b1;
					next_fin = 1'b0;
					next_post = !src_disk;
					next_st = ST_IDLE;
					if (rows < 2'(apl_pkg::MIN_MAIN_ROWS)) begin
						next_dflt = 1'b1;
						next_err_valid = 1'b1;
						next_err = apl_pkg::ERR_SHORT_MAIN;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			ln <= '0;
			cur <= 32'h0;
			infield <= 1'b0;
			fidx <= 8'h00;
			mk <= MK_START;
			nlab <= 7'h00;
			used <= 7'h00;
			cnt <= '0;
			main_seq <= 1'b0;
			rows <= 2'h0;
			post <= 1'b0;
			fin <= 1'b0;
			ei <= 7'h00;
			efc <= 8'h00;
			ev1 <= 1'b0;
			ei1 <= 7'h00;
			rmt_valid <= 1'b0;
			rmt_data <= 8'h00;
			seq_clear <= 1'b0;
			lbl_valid <= 1'b0;
			lbl <= '0;
			fmt_valid <= 1'b0;
			fmt_sel <= apl_pkg::FMT_MODE;
			vec_valid <= 1'b0;
			vec <= '0;
			load_done <= 1'b0;
			dflt_main <= 1'b0;
			err_valid <= 1'b0;
			err_code <= apl_pkg::ERR_NONE;
		end else begin
			st <= next_st;
			ln <= next_ln;
			cur <= next_cur;
			infield <= next_infield;
			fidx <= next_fidx;
			mk <= next_mk;
			nlab <= next_nlab;
			used <= next_used;
			cnt <= next_cnt;
			main_seq <= next_main;
			rows <= next_rows;
			post <= next_post;
			fin <= next_fin;
			ei <= next_ei;
			efc <= next_efc;
			ev1 <= next_ev1;
			ei1 <= next_ei1;
			rmt_valid <= next_rmt_valid;
			rmt_data <= next_rmt_data;
			seq_clear <= next_clear;
			lbl_valid <= next_lbl_valid;
			lbl <= next_lbl;
			fmt_valid <= next_fmt_valid;
			fmt_sel <= next_fmt;
			vec_valid <= next_vec_valid;
			vec <= next_vec;
			load_done <= next_done;
			dflt_main <= next_dflt;
			err_valid <= next_err_valid;
			err_code <= next_err;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_begin_clears;
		line_end && ln.kw == apl_pkg::KW_BEGIN |=> seq_clear && nlab == 7'h00 && st == ST_SETUP;
	endproperty
	a_begin_clears: assert property (p_begin_clears) else $error("load begin did not clear");

	property p_fmt_label;
		line_end && st == ST_SETUP && ln.kw == apl_pkg::KW_FORM && ln.sub == apl_pkg::SUB_LABEL
			|=> err_valid && err_code == apl_pkg::ERR_FMT_LABEL && !fmt_valid;
	endproperty
	a_fmt_label: assert property (p_fmt_label) else $error("format label not refused");

	property p_lbl_width;
		lbl_valid |-> lbl.width >= 6'h01 && lbl.width <= 6'h20;
	endproperty
	a_lbl_width: assert property (p_lbl_width) else $error("label width out of range");

	property p_lbl_contig;
		lbl_valid |-> int'(lbl.msb) + int'(used) == OUT_BITS - 1 + int'(lbl.width);
	endproperty
	a_lbl_contig: assert property (p_lbl_contig) else $error("label bits not contiguous");

	property p_lbl_cap;
		int'(nlab) <= NUM_LABELS && int'(used) <= OUT_BITS;
	endproperty
	a_lbl_cap: assert property (p_lbl_cap) else $error("label table overfilled");

	property p_count_down;
		st == ST_DATA && in_fire && !src_disk |=> (cnt + 1'b1) == $past(cnt);
	endproperty
	a_count_down: assert property (p_count_down) else $error("byte count not decremented");

	property p_trunc;
		vec_valid |-> (vec.val & ~mask_of(vec.width)) == 32'h0;
	endproperty
	a_trunc: assert property (p_trunc) else $error("field wider than its label");

	property p_skip_empty;
		st == ST_DATA && in_fire && is_term && fcount == 8'h00 |=> st != ST_EMIT;
	endproperty
	a_skip_empty: assert property (p_skip_empty) else $error("empty row emitted");

	property p_marker;
		st == ST_DATA && in_fire && is_term && mk == MK_DONE |=> main_seq && st != ST_EMIT;
	endproperty
	a_marker: assert property (p_marker) else $error("marker row did not switch");

	property p_overrun;
		st == ST_IDLE && post && in_fire && in_data != apl_pkg::CH_LF
			|=> err_valid && err_code == apl_pkg::ERR_OVERRUN && rmt_valid;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_default_main;
		st == ST_FINISH && !ev1 && rows < 2'h2 |=> load_done && dflt_main ##1 st == ST_IDLE;
	endproperty
	a_default_main: assert property (p_default_main) else $error("default main not installed");
endmodule : apl_loader

// ==== tb/apl_sender.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Byte source standing in for the remote controller
// ----------------------------------------------------------------
module apl_sender (
	input wire logic clk,
	input wire logic in_ready,
	output logic in_valid,
	output logic [7:0] in_data,
	output logic stuck
);
	int gap = 0;
	logic rdy_s;
	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		stuck = 1'b0;
	end
	// Ready only moves just after a rising edge, so the mid-cycle sample is the edge value.
	always @(negedge clk) rdy_s = in_ready;
	// A byte is held until taken; afterwards the line shows the inverse, so stale data
	// cannot pass for a fresh byte.
	task automatic send(input string s);
		int t;
		for (int k = 0; k < s.len(); k++) begin
			repeat (gap) @(posedge clk);
			#1;
			in_valid = 1'b1;
			in_data = s[k];
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (rdy_s !== 1'b1 && t < 200);
			if (t >= 200) stuck = 1'b1;
			#1;
			in_valid = 1'b0;
			in_data = ~s[k];
		end
	endtask : send
endmodule : apl_sender

// ==== tb/tb_ascii_pattern_file_loader.sv ====
`timescale 1ns/1ns
module tb_ascii_pattern_file_loader;
	typedef struct {
		string s;
		int n;
		logic [31:0] a;
		logic [31:0] b;
		logic m;
	} apl_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic src_disk = 1'b0;
	logic src_eof = 1'b0;
	logic in_valid, in_ready, rmt_valid, seq_clear, lbl_valid, fmt_valid, vec_valid;
	logic load_done, dflt_main, err_valid, stuck;
	logic [7:0] in_data, rmt_data;
	apl_pkg::apl_lbl_t lbl;
	apl_pkg::apl_fmt_t fmt_sel;
	apl_pkg::apl_vec_t vec;
	apl_pkg::apl_err_t err_code;
	int n_errors = 0;
	int comparisons = 0;
	int n_clr = 0;
	int n_done = 0;
	int n_dflt = 0;
	int cnt;
	apl_pkg::apl_lbl_t lq[$];
	apl_pkg::apl_fmt_t fq[$];
	apl_pkg::apl_vec_t vq[$];
	apl_pkg::apl_err_t eq[$];
	logic [7:0] rq[$];
	string fs[3] = '{"FORM:MODE FULL\n", "FORM:CLOCK INT\n", "FORM:DELAY 0\n"};
	apl_row_t rows[8] = '{'{"12 34\n", 2, 32'h12, 32'h4, 1'b0}, '{"1g2\n", 2, 32'h1, 32'h2, 1'b0},
		'{"5\n", 2, 32'h5, 32'h0, 1'b0}, '{"6 7 8\n", 2, 32'h6, 32'h7, 1'b0},
		'{"\n", 0, 32'h0, 32'h0, 1'b0}, '{"*M\n", 0, 32'h0, 32'h0, 1'b0},
		'{"9 a\n", 2, 32'h9, 32'ha, 1'b1}, '{"bc DE\r\n", 2, 32'hbc, 32'he, 1'b1}};

	always #20 clk = ~clk;

	apl_loader i_apl_loader (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .src_disk(src_disk), .src_eof(src_eof), .rmt_valid(rmt_valid),
		.rmt_data(rmt_data), .seq_clear(seq_clear), .lbl_valid(lbl_valid), .lbl(lbl),
		.fmt_valid(fmt_valid), .fmt_sel(fmt_sel), .vec_valid(vec_valid), .vec(vec),
		.load_done(load_done), .dflt_main(dflt_main), .err_valid(err_valid),
		.err_code(err_code));
	apl_sender i_apl_sender (.clk(clk), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .stuck(stuck));

	// ----------------------------------------------------------------
	// Monitor
	// ----------------------------------------------------------------
	// Pulses last a full cycle, so a mid-cycle sample sees each exactly once.
	always @(negedge clk) begin
		if (seq_clear === 1'b1) n_clr++;
		if (load_done === 1'b1) n_done++;
		if (dflt_main === 1'b1) n_dflt++;
		if (lbl_valid === 1'b1) lq.push_back(lbl);
		if (fmt_valid === 1'b1) fq.push_back(fmt_sel);
		if (vec_valid === 1'b1) vq.push_back(vec);
		if (err_valid === 1'b1) eq.push_back(err_code);
		if (rmt_valid === 1'b1) rq.push_back(rmt_data);
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task chk_err(input apl_pkg::apl_err_t exp);
		apl_pkg::apl_err_t got;
		got = (eq.size() > 0) ? eq.pop_front() : apl_pkg::ERR_NONE;
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
		eq.delete();
	endtask : chk_err

	task stop_test;
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	task line(input string s);
		i_apl_sender.send(s);
		repeat (8) @(posedge clk);
	endtask : line

	always @(posedge stuck) begin
		n_errors++;
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
		#2;
		chk({in_ready, err_code, fmt_sel, lbl_valid, vec_valid},
			{1'b1, apl_pkg::ERR_NONE, apl_pkg::FMT_MODE, 2'b00});
		line("LABEL 'Z',4\n");
		chk_err(apl_pkg::ERR_ORDER);
		line("ASCD\n");
		chk(n_clr, 1);
		for (int k = 0; k < 3; k++) begin
			line(fs[k]);
			chk(fq.pop_front(), apl_pkg::apl_fmt_t'(k));
		end
		line("FORM:LABEL 'Q',4\n");
		chk_err(apl_pkg::ERR_FMT_LABEL);
		line("LABEL 'A',8\n");
		line("LABEL 'B',4\n");
		chk({lq[0].idx, lq[0].msb, lq[0].width}, {7'd0, 6'd31, 6'd8});
		chk({lq[1].idx, lq[1].msb, lq[1].width}, {7'd1, 6'd23, 6'd4});
		line("LABEL 'C',33\n");
		chk_err(apl_pkg::ERR_LABEL);
		line("LABEL 'D',21\n");
		chk_err(apl_pkg::ERR_LABEL);
		chk(lq.size(), 2);
		cnt = 1;
		foreach (rows[k]) cnt += rows[k].s.len();
		line($sformatf("VECT #8%08d\n", cnt));
		foreach (rows[k]) begin
			line(rows[k].s);
			chk(vq.size(), rows[k].n);
			if (vq.size() == 2) begin
				chk({vq[0].idx, vq[0].val, vq[0].main, vq[0].last},
					{7'd0, rows[k].a, rows[k].m, 1'b0});
				chk({vq[1].idx, vq[1].val, vq[1].main, vq[1].last},
					{7'd1, rows[k].b, rows[k].m, 1'b1});
			end
			vq.delete();
			chk(n_done, k == 7);
		end
		chk(n_dflt, 0);
		chk_err(apl_pkg::ERR_NONE);
		line("\n");
		chk_err(apl_pkg::ERR_NONE);
		// The flush byte used up the overrun check, so a fresh bus load re-arms it.
		line("ascd\nQQQQ\n");
		chk_err(apl_pkg::ERR_UNKNOWN);
		line("VECT #81\n");
		chk_err(apl_pkg::ERR_HEADER);
		chk(n_done, 2);
		chk(n_dflt, 1);
		rq.delete();
		line("X\n");
		chk(rq[0], 8'h58);
		chk_err(apl_pkg::ERR_OVERRUN);
		#1 src_disk = 1'b1;
		i_apl_sender.gap = 2;
		line("ASCD\nLABEL 'Q',4\nVECT #800000001\n*M\n1\n2");
		chk(n_done, 2);
		#1 src_eof = 1'b1;
		@(posedge clk);
		#1 src_eof = 1'b0;
		repeat (8) @(posedge clk);
		chk(n_done, 3);
		chk(vq.size(), 1);
		chk(n_dflt, 2);
		chk_err(apl_pkg::ERR_SHORT_MAIN);
		stop_test();
	end
endmodule : tb_ascii_pattern_file_loader
